//--- rtl/irq_status_pkg.sv
// Purpose: shared constants and carrier types for the peripheral interrupt status bank
// Assumes: 32-bit apb data, one aligned word per register
// Notes: printed offsets are byte addresses
package irq_status_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_CODEC_STATUS = 12'h0100;
  localparam logic [11:0] OFS_UART_STATUS = 12'h0104;
  localparam logic [11:0] OFS_MFIO_RISE = 12'h0108;
  localparam logic [11:0] OFS_MFIO_FALL = 12'h010c;
  localparam logic [11:0] OFS_SYSTEM_STATUS = 12'h0110;
  localparam logic [11:0] OFS_SUMMARY_STATUS = 12'h0114;
  localparam logic [11:0] OFS_ENABLE_BASE = 12'h0118;
  localparam logic [11:0] OFS_GLOBAL_CTRL = 12'h012c;
  localparam logic [11:0] OFS_AUX_CTRL = 12'h0130;
  localparam int NUM_BANKS = 5;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int B_SND_RISE = 14;
  localparam int B_SND_FALL = 13;
  localparam int B_TEL_RISE = 12;
  localparam int B_TEL_FALL = 11;
  localparam int B_SND_WORD = 10;
  localparam int B_TEL_WORD = 9;
  localparam int B_SF0_START = 8;
  localparam int B_SF1_START = 7;
  localparam int B_CODEC_RISE = 6;
  localparam int B_CODEC_FALL = 5;
  localparam int UART_FIELD_W = 10;
  localparam int UART_A_LSB = 22;
  localparam int UART_B_LSB = 12;
  localparam int B_ALARM = 30;
  localparam int B_PERIODIC = 29;
  localparam int B_STOP = 28;
  localparam int B_PWR_RISE = 27;
  localparam int B_PWR_FALL = 26;
  localparam int B_PGOOD_RISE = 25;
  localparam int B_PGOOD_FALL = 24;
  localparam int B_BTN_RISE = 23;
  localparam int B_BTN_FALL = 22;
  localparam int B_SER_FREE = 21;
  localparam int B_SER_OVR = 20;
  localparam int B_SER_RCV = 19;
  localparam int B_SER_IDLE = 18;
  localparam int GP_RISE_LSB = 7;
  localparam int GP_FALL_LSB = 0;
  localparam int GP_PINS = 7;
  localparam int B_REQ_LOW = 30;
  localparam int B_GLOBAL_EN = 18;
  localparam int B_DEBOUNCE_EN = 0;
  localparam logic [31:0] PRIO_MASK_BITS = 32'h0000_ffff;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int DEBOUNCE_NS = 16_000_000;
  localparam int DEBOUNCE_CYCLES = (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic sound_valid_sf0;
    logic sound_valid_sf1;
    logic sound_subframe_select;
    logic telecom_valid_sf0;
    logic telecom_valid_sf1;
    logic telecom_subframe_select;
    logic sound_word_ready;
    logic telecom_word_ready;
    logic subframe0_start;
    logic subframe1_start;
  } codec_ev_s;

  typedef struct packed {
    logic rx_load;
    logic rx_framing_err;
    logic rx_break;
    logic rx_parity_err;
    logic tx_free;
    logic tx_write;
    logic tx_idle;
    logic dma_mid;
    logic dma_end;
  } uart_ev_s;

  typedef struct packed {
    logic serial_port_enable;
    logic tx_move;
    logic tx_write;
    logic rx_move;
    logic shift_empty;
    logic hold_empty;
  } serial_ev_s;

endpackage : irq_status_pkg

//--- rtl/peripheral_interrupt_status_bank.sv
// Purpose: sticky interrupt status, enables and low-priority request behind apb
// Assumes: peripheral event inputs are on pclk; pins arrive asynchronously
// Notes: one wait state on every apb access
//
// What this block does
// - codec valid flags from chosen subframe set separate rise and fall bits.
// - sound or telecom word ready sets its holding status.
// - start of subframe 0 and subframe 1 each set their own bit.
// - codec request pin rise and fall each set a bit.
// - uart status: channel a in 31..22, b in 21..12, low bits zero.
// - uart receive holding load sets the receive bit.
// - second receive load before service sets receive overrun.
// - framing, parity and break of current character each set a bit.
// - transmit holding free sets a bit; both transmit registers empty another.
// - transmit write while holding not free sets transmit overrun.
// - uart dma midpoint and buffer end each set a bit.
// - two 32-bit pin registers hold rising and falling edges per pin.
// - general pin rise bits sit at 13..7, fall bits at 6..0.
// - alarm bit sets when real-time count equals 40-bit alarm value.
// - periodic bit sets when timer enabled and its count is zero.
// - stop bit sets when stop counter reaches its 4-bit limit.
// - power pin and power-good each set separate rise and fall bits.
// - on-button edges set bits; with debounce, only after stable interval.
// - serial buffer free sets on first enable and each holding-to-shift move.
// - serial holding write before buffer free sets the error bit.
// - serial shift-to-receive-holding transfer sets receive bit.
// - serial idle sets when shift and holding registers both empty.
// - writing one to a status bit clears it; zero does nothing.
// - request is global enable and any enabled status bit.
// - reset clears every status bit.
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
module peripheral_interrupt_status_bank #(
  parameter int DEBOUNCE_CYCLES = irq_status_pkg::DEBOUNCE_CYCLES,
  parameter int PERIOD_WIDTH = 16,
  parameter int RTC_WIDTH = 40,
  parameter int STOP_WIDTH = 4,
  parameter int MFIO_PINS = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire irq_status_pkg::codec_ev_s codec_ev,
  input wire irq_status_pkg::uart_ev_s uart_a_ev,
  input wire irq_status_pkg::uart_ev_s uart_b_ev,
  input wire irq_status_pkg::serial_ev_s serial_ev,
  input wire logic codec_bus_request_pin,
  input wire logic [MFIO_PINS-1:0] multi_pin,
  input wire logic [irq_status_pkg::GP_PINS-1:0] gp_pin,
  input wire logic power_event_pin,
  input wire logic power_good_signal,
  input wire logic on_button_signal,
  input wire logic [RTC_WIDTH-1:0] rtc_count,
  input wire logic [RTC_WIDTH-1:0] alarm_value,
  input wire logic periodic_enable,
  input wire logic [PERIOD_WIDTH-1:0] periodic_count,
  input wire logic [STOP_WIDTH-1:0] stop_count,
  input wire logic [STOP_WIDTH-1:0] stop_count_limit,
  output logic low_priority_request
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  localparam int GP = irq_status_pkg::GP_PINS;
  localparam int NPIN = 1 + MFIO_PINS + GP + 3;
  localparam int CNT_W = $clog2(DEBOUNCE_CYCLES + 1);
  localparam logic [CNT_W-1:0] DEB_LAST = CNT_W'(DEBOUNCE_CYCLES - 1);

  // set wins over clear so an event in the clearing cycle survives
  function automatic logic [31:0] sticky(input logic [31:0] cur, input logic [31:0] set,
                                         input logic [31:0] clr);
    sticky = (cur & ~clr) | set;
  endfunction : sticky

  // uart field, msb first: rx, rx overrun, framing, break, parity,
  // tx free, tx overrun, idle, dma end, dma mid
  function automatic logic [9:0] uart_field(input irq_status_pkg::uart_ev_s ev,
                                            input logic rx_pending);
    uart_field = {ev.rx_load, ev.rx_load & rx_pending, ev.rx_framing_err, ev.rx_break,
                  ev.rx_parity_err, ev.tx_free, ev.tx_write & ~ev.tx_free, ev.tx_idle,
                  ev.dma_end, ev.dma_mid};
  endfunction : uart_field

  // map an offset onto a status bank number, zero when none
  function automatic logic [2:0] status_bank(input logic [11:0] ofs);
    case (ofs)
      irq_status_pkg::OFS_CODEC_STATUS: status_bank = 3'h1;
      irq_status_pkg::OFS_UART_STATUS: status_bank = 3'h2;
      irq_status_pkg::OFS_MFIO_RISE: status_bank = 3'h3;
      irq_status_pkg::OFS_MFIO_FALL: status_bank = 3'h4;
      irq_status_pkg::OFS_SYSTEM_STATUS: status_bank = 3'h5;
      default: status_bank = 3'h0;
    endcase
  endfunction : status_bank

  // map an offset onto an enable bank number, zero when none
  function automatic logic [2:0] enable_bank(input logic [11:0] ofs);
    enable_bank = 3'h0;
    for (int i = 0; i < irq_status_pkg::NUM_BANKS; i++)
    begin
      if (ofs == irq_status_pkg::OFS_ENABLE_BASE + 12'(4 * i))
      begin
        enable_bank = 3'(i + 1);
      end
    end
  endfunction : enable_bank

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_meta_ff;
  logic [NPIN-1:0] pin_sync_ff;
  logic [NPIN-1:0] pin_prev_ff;

  assign pin_raw = {on_button_signal, power_good_signal, power_event_pin, gp_pin, multi_pin,
                    codec_bus_request_pin};

  genvar g;
  generate
    for (g = 0; g < NPIN; g++)
    begin : g_sync
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          pin_meta_ff[g] <= 1'b0;
          pin_sync_ff[g] <= 1'b0;
        end
        else
        begin
          pin_meta_ff[g] <= pin_raw[g];
          pin_sync_ff[g] <= pin_meta_ff[g];
        end
      end
    end
  endgenerate

  // the button edge comes from the debounced level, not the raw one
  logic btn_level;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_prev_ff <= '0;
    end
    else
    begin
      pin_prev_ff <= {btn_level, pin_sync_ff[NPIN-2:0]};
    end
  end

  logic [NPIN-1:0] pin_now;
  logic [NPIN-1:0] pin_rise;
  logic [NPIN-1:0] pin_fall;

  assign pin_now = {btn_level, pin_sync_ff[NPIN-2:0]};
  assign pin_rise = pin_now & ~pin_prev_ff;
  assign pin_fall = ~pin_now & pin_prev_ff;

  // ----------------------------------------------------------------
  // on-button debounce
  // ----------------------------------------------------------------
  logic aux_ctrl_ff;
  logic btn_deb_ff;
  logic [CNT_W-1:0] btn_cnt_ff;

  // the level moves only after the pin held its new value for the whole interval
  // debounce filter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      btn_deb_ff <= 1'b0;
      btn_cnt_ff <= '0;
    end
    else if (!aux_ctrl_ff || (pin_sync_ff[NPIN-1] == btn_deb_ff))
    begin
      btn_deb_ff <= pin_sync_ff[NPIN-1];
      btn_cnt_ff <= '0;
    end
    else if (btn_cnt_ff == DEB_LAST)
    begin
      btn_deb_ff <= pin_sync_ff[NPIN-1];
      btn_cnt_ff <= '0;
    end
    else
    begin
      btn_cnt_ff <= btn_cnt_ff + 1'b1;
    end
  end

  assign btn_level = btn_deb_ff;

  // ----------------------------------------------------------------
  // internal level edges
  // ----------------------------------------------------------------
  logic snd_valid;
  logic tel_valid;
  logic snd_valid_prev_ff;
  logic tel_valid_prev_ff;
  logic ser_en_prev_ff;
  logic ser_free_ff;

  assign snd_valid = codec_ev.sound_subframe_select ? codec_ev.sound_valid_sf1 :
                     codec_ev.sound_valid_sf0;
  assign tel_valid = codec_ev.telecom_subframe_select ? codec_ev.telecom_valid_sf1 :
                     codec_ev.telecom_valid_sf0;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      snd_valid_prev_ff <= 1'b0;
      tel_valid_prev_ff <= 1'b0;
      ser_en_prev_ff <= 1'b0;
    end
    else
    begin
      snd_valid_prev_ff <= snd_valid;
      tel_valid_prev_ff <= tel_valid;
      ser_en_prev_ff <= serial_ev.serial_port_enable;
    end
  end

  logic ser_en_rise;
  assign ser_en_rise = serial_ev.serial_port_enable & ~ser_en_prev_ff;

  // holding register counts as free from enable or a move until the next write
  // free tracking
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ser_free_ff <= 1'b0;
    end
    else if (ser_en_rise || serial_ev.tx_move)
    begin
      ser_free_ff <= 1'b1;
    end
    else if (serial_ev.tx_write)
    begin
      ser_free_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // set vectors
  // ----------------------------------------------------------------
  logic [31:0] status_ff [1:irq_status_pkg::NUM_BANKS];
  logic [31:0] enable_ff [1:irq_status_pkg::NUM_BANKS];
  logic [31:0] set_vec [1:irq_status_pkg::NUM_BANKS];
  logic [31:0] clr_vec [1:irq_status_pkg::NUM_BANKS];

  always_comb
  begin
    set_vec[1] = irq_status_pkg::RESET_WORD;
    set_vec[1][irq_status_pkg::B_SND_RISE] = snd_valid & ~snd_valid_prev_ff;
    set_vec[1][irq_status_pkg::B_SND_FALL] = ~snd_valid & snd_valid_prev_ff;
    set_vec[1][irq_status_pkg::B_TEL_RISE] = tel_valid & ~tel_valid_prev_ff;
    set_vec[1][irq_status_pkg::B_TEL_FALL] = ~tel_valid & tel_valid_prev_ff;
    set_vec[1][irq_status_pkg::B_SND_WORD] = codec_ev.sound_word_ready;
    set_vec[1][irq_status_pkg::B_TEL_WORD] = codec_ev.telecom_word_ready;
    set_vec[1][irq_status_pkg::B_SF0_START] = codec_ev.subframe0_start;
    set_vec[1][irq_status_pkg::B_SF1_START] = codec_ev.subframe1_start;
    set_vec[1][irq_status_pkg::B_CODEC_RISE] = pin_rise[0];
    set_vec[1][irq_status_pkg::B_CODEC_FALL] = pin_fall[0];
  end

  assign set_vec[2] = {uart_field(uart_a_ev, status_ff[2][31]),
                       uart_field(uart_b_ev, status_ff[2][21]),
                       12'h000};

  assign set_vec[3] = 32'(pin_rise[MFIO_PINS:1]);
  assign set_vec[4] = 32'(pin_fall[MFIO_PINS:1]);

  always_comb
  begin
    set_vec[5] = irq_status_pkg::RESET_WORD;
    set_vec[5][irq_status_pkg::B_ALARM] = (rtc_count == alarm_value);
    set_vec[5][irq_status_pkg::B_PERIODIC] = periodic_enable && (periodic_count == '0);
    set_vec[5][irq_status_pkg::B_STOP] = (stop_count == stop_count_limit);
    set_vec[5][irq_status_pkg::B_PWR_RISE] = pin_rise[NPIN-3];
    set_vec[5][irq_status_pkg::B_PWR_FALL] = pin_fall[NPIN-3];
    set_vec[5][irq_status_pkg::B_PGOOD_RISE] = pin_rise[NPIN-2];
    set_vec[5][irq_status_pkg::B_PGOOD_FALL] = pin_fall[NPIN-2];
    set_vec[5][irq_status_pkg::B_BTN_RISE] = pin_rise[NPIN-1];
    set_vec[5][irq_status_pkg::B_BTN_FALL] = pin_fall[NPIN-1];
    set_vec[5][irq_status_pkg::B_SER_FREE] = ser_en_rise | serial_ev.tx_move;
    set_vec[5][irq_status_pkg::B_SER_OVR] = serial_ev.tx_write & ~ser_free_ff;
    set_vec[5][irq_status_pkg::B_SER_RCV] = serial_ev.rx_move;
    set_vec[5][irq_status_pkg::B_SER_IDLE] = serial_ev.shift_empty & serial_ev.hold_empty;
    for (int i = 0; i < GP; i++)
    begin
      set_vec[5][irq_status_pkg::GP_RISE_LSB + i] = pin_rise[1 + MFIO_PINS + i];
      set_vec[5][irq_status_pkg::GP_FALL_LSB + i] = pin_fall[1 + MFIO_PINS + i];
    end
  end

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_rdata;
  logic nxt_err;
  logic done;
  logic wr_done;
  logic [11:0] ofs;
  logic [31:0] wmask;
  logic global_en_ff;
  logic [15:0] prio_mask_ff;
  logic req_ff;

  assign ofs = paddr[11:0];
  assign done = psel & penable & pready_ff;
  assign wr_done = done & pwrite & ~pslverr_ff;
  assign wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

  always_comb
  begin
    nxt_err = 1'b0;
    nxt_rdata = irq_status_pkg::RESET_WORD;
    if (status_bank(ofs) != 3'h0)
    begin
      nxt_rdata = status_ff[status_bank(ofs)];
    end
    else if (enable_bank(ofs) != 3'h0)
    begin
      nxt_rdata = enable_ff[enable_bank(ofs)];
    end
    else if (ofs == irq_status_pkg::OFS_SUMMARY_STATUS)
    begin
      nxt_rdata[irq_status_pkg::B_REQ_LOW] = req_ff;
    end
    else if (ofs == irq_status_pkg::OFS_GLOBAL_CTRL)
    begin
      nxt_rdata = 32'(prio_mask_ff);
      nxt_rdata[irq_status_pkg::B_GLOBAL_EN] = global_en_ff;
    end
    else if (ofs == irq_status_pkg::OFS_AUX_CTRL)
    begin
      nxt_rdata[irq_status_pkg::B_DEBOUNCE_EN] = aux_ctrl_ff;
    end
    else
    begin
      nxt_err = 1'b1;
    end
    if (paddr[31:12] != '0 || paddr[1:0] != 2'b00)
    begin
      nxt_err = 1'b1;
    end
  end

  // answer one cycle into the access phase so read data comes from flip-flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= irq_status_pkg::RESET_WORD;
    end
    else if (psel && penable && !pready_ff)
    begin
      pready_ff <= 1'b1;
      pslverr_ff <= nxt_err;
      prdata_ff <= pwrite ? irq_status_pkg::RESET_WORD : nxt_rdata;
    end
    else
    begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end
  end

  assign pready = pready_ff;
  assign pslverr = pslverr_ff & pready_ff;
  assign prdata = prdata_ff;

  // ----------------------------------------------------------------
  // status, enable and control registers
  // ----------------------------------------------------------------
  generate
    for (g = 1; g <= irq_status_pkg::NUM_BANKS; g++)
    begin : g_bank
      assign clr_vec[g] = (wr_done && status_bank(ofs) == 3'(g)) ? (pwdata & wmask) :
                          irq_status_pkg::RESET_WORD;

      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          status_ff[g] <= irq_status_pkg::RESET_WORD;
        end
        else
        begin
          status_ff[g] <= sticky(status_ff[g], set_vec[g], clr_vec[g]);
        end
      end

      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          enable_ff[g] <= irq_status_pkg::RESET_WORD;
        end
        else if (wr_done && enable_bank(ofs) == 3'(g))
        begin
          enable_ff[g] <= (enable_ff[g] & ~wmask) | (pwdata & wmask);
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      global_en_ff <= 1'b0;
      prio_mask_ff <= '0;
      aux_ctrl_ff <= 1'b0;
    end
    else if (wr_done && ofs == irq_status_pkg::OFS_GLOBAL_CTRL)
    begin
      if (pstrb[2])
      begin
        global_en_ff <= pwdata[irq_status_pkg::B_GLOBAL_EN];
      end
      prio_mask_ff <= 16'((prio_mask_ff & wmask[15:0]) == '0 ?
                          (pwdata & irq_status_pkg::PRIO_MASK_BITS & wmask) :
                          ((32'(prio_mask_ff) & ~wmask) | (pwdata & wmask)));
    end
    else if (wr_done && ofs == irq_status_pkg::OFS_AUX_CTRL && pstrb[0])
    begin
      aux_ctrl_ff <= pwdata[irq_status_pkg::B_DEBOUNCE_EN];
    end
  end

  // ----------------------------------------------------------------
  // request
  // ----------------------------------------------------------------
  logic any_enabled;

  always_comb
  begin
    any_enabled = 1'b0;
    for (int i = 1; i <= irq_status_pkg::NUM_BANKS; i++)
    begin
      any_enabled = any_enabled | (|(status_ff[i] & enable_ff[i]));
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      req_ff <= 1'b0;
    end
    else
    begin
      req_ff <= global_en_ff & any_enabled;
    end
  end

  assign low_priority_request = req_ff;

endmodule : peripheral_interrupt_status_bank

//--- tb/pisb_asserts.sv
// Purpose: port checks for the status bank
// Assumes: one wait state apb slave
// Notes: sees bus ports only
`timescale 1ns/1ps
module pisb_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held");
  ready_access_a: assert property (pready |-> psel && penable && $past(psel && penable))
    else $error("ready outside access");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  wr_zero_a: assert property (pready && pwrite |-> prdata == 32'h0000_0000)
    else $error("write returned data");
  high_addr_a: assert property (pready && paddr[31:12] != 20'h0_0000 |-> pslverr)
    else $error("high address accepted");
  misalign_a: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("misaligned accepted");
  uart_rsvd_a: assert property (pready && !pwrite && paddr == 32'h0000_0104 |-> prdata[11:0] == 12'h000)
    else $error("uart low bits set");
  sys_rsvd_a: assert property (pready && !pwrite && paddr == 32'h0000_0110 |-> prdata[17:14] == 4'h0)
    else $error("system spare bits set");
endmodule : pisb_asserts
bind peripheral_interrupt_status_bank pisb_asserts pisb_asserts_inst (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr));

//--- tb/cpu_apb_model.sv
// Purpose: cpu side apb master reading and clearing status
// Assumes: waits for pready, never a fixed count
// Notes: to counts timed out transfers
`timescale 1ns/1ps
module cpu_apb_model (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  int to = 0;
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hf;
  end
  task xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 40)
    begin
      @(posedge pclk);
      n++;
    end
    r = prdata;
    e = pslverr;
    if (n == 40) to++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer
endmodule : cpu_apb_model

//--- tb/peripheral_interrupt_status_bank_tb_top.sv
// Purpose: directed bench for the status bank
// Assumes: debounce shortened to 8 cycles
// Notes: codec events, serial, button inputs held idle; one pin level drives power, power-good and codec request
`timescale 1ns/1ps
`define CHK(g, x) begin checked++; if ((g) !== (x)) begin error_cnt++; \
  $display("CHECK FAILED %0t got %h want %h", $time, g, x); end end
module peripheral_interrupt_status_bank_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, lpr, pwr_pin;
  logic [31:0] paddr, pwdata, prdata, mpin;
  logic [3:0] pstrb, stop_cnt;
  logic [6:0] gpin;
  logic [39:0] rtc, alarm;
  logic per_en;
  irq_status_pkg::uart_ev_s ua, ub;
  int error_cnt = 0;
  int checked = 0;
  always #2 pclk = ~pclk;
  cpu_apb_model cpu_apb_model_inst (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  peripheral_interrupt_status_bank #(.DEBOUNCE_CYCLES(8)) peripheral_interrupt_status_bank_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .codec_ev('0), .uart_a_ev(ua), .uart_b_ev(ub), .serial_ev('0), .codec_bus_request_pin(pwr_pin),
    .multi_pin(mpin), .gp_pin(gpin), .power_event_pin(pwr_pin), .power_good_signal(pwr_pin),
    .on_button_signal(1'b0), .rtc_count(rtc), .alarm_value(alarm), .periodic_enable(per_en),
    .periodic_count(16'h0000), .stop_count(stop_cnt), .stop_count_limit(4'h1), .low_priority_request(lpr));
  task tally_and_finish;
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish
  task xf(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
    cpu_apb_model_inst.xfer(w, a, d, r, e);
    if (cpu_apb_model_inst.to != 0)
    begin
      error_cnt++;
      tally_and_finish;
    end
  endtask : xf
  task rd(input logic [31:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    xf(1'b0, a, 32'h0, r, e);
    `CHK(r, x)
    `CHK(e, xe)
  endtask : rd
  task wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    xf(1'b1, a, d, r, e);
  endtask : wr
  task t_reset;
    rd(32'h0000_0104, 32'h0000_0000, 1'b0);
    rd(32'h0000_0110, 32'h0000_0000, 1'b0);
    rd(32'h0000_012c, 32'h0000_0000, 1'b0);
  endtask : t_reset
  task t_pins;
    mpin <= 32'h8000_0001;
    gpin <= 7'h41;
    pwr_pin <= 1'b1;
    repeat (6) @(posedge pclk);
    rd(32'h0000_0108, 32'h8000_0001, 1'b0);
    rd(32'h0000_0110, 32'h0a00_2080, 1'b0);
    rd(32'h0000_0100, 32'h0000_0040, 1'b0);
    wr(32'h0000_0108, 32'hffff_ffff);
    rd(32'h0000_0108, 32'h0000_0000, 1'b0);
    mpin <= 32'h0000_0000;
    gpin <= 7'h00;
    pwr_pin <= 1'b0;
    repeat (6) @(posedge pclk);
    wr(32'h0000_010c, 32'h0000_0000);
    rd(32'h0000_010c, 32'h8000_0001, 1'b0);
    rd(32'h0000_0110, 32'h0f00_20c1, 1'b0);
    rd(32'h0000_0100, 32'h0000_0060, 1'b0);
    wr(32'h0000_0100, 32'hffff_ffff);
    rd(32'h0000_0100, 32'h0000_0000, 1'b0);
    wr(32'h0000_0110, 32'hffff_ffff);
    wr(32'h0000_010c, 32'hffff_ffff);
    rd(32'h0000_0110, 32'h0000_0000, 1'b0);
  endtask : t_pins
  task t_uart;
    ua.rx_load <= 1'b1;
    @(posedge pclk);
    ua.rx_load <= 1'b0;
    @(posedge pclk);
    ua.rx_load <= 1'b1;
    ub.dma_mid <= 1'b1;
    @(posedge pclk);
    ua.rx_load <= 1'b0;
    ub.dma_mid <= 1'b0;
    @(posedge pclk);
    rd(32'h0000_0104, 32'hc000_1000, 1'b0);
    wr(32'h0000_0104, 32'hffff_ffff);
    rd(32'h0000_0104, 32'h0000_0000, 1'b0);
  endtask : t_uart
  task t_sys;
    rtc <= 40'h00_0000_0005;
    alarm <= 40'h00_0000_0005;
    per_en <= 1'b1;
    stop_cnt <= 4'h1;
    @(posedge pclk);
    alarm <= 40'h00_0000_0006;
    per_en <= 1'b0;
    stop_cnt <= 4'h0;
    @(posedge pclk);
    rd(32'h0000_0110, 32'h7000_0000, 1'b0);
  endtask : t_sys
  task t_irq;
    rd(32'h0000_0114, 32'h0000_0000, 1'b0);
    rd(32'h0000_0110, 32'h7000_0000, 1'b0);
    wr(32'h0000_0128, 32'h4000_0000);
    `CHK(lpr, 1'b0)
    wr(32'h0000_012c, 32'h0004_0000);
    rd(32'h0000_0114, 32'h4000_0000, 1'b0);
    `CHK(lpr, 1'b1)
    wr(32'h0000_0110, 32'hffff_ffff);
    rd(32'h0000_0114, 32'h0000_0000, 1'b0);
    `CHK(lpr, 1'b0)
    rd(32'h0000_0200, 32'h0000_0000, 1'b1);
    rd(32'h0001_0100, 32'h0000_0000, 1'b1);
    rd(32'h0000_0106, 32'h0000_0000, 1'b1);
  endtask : t_irq
  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    {mpin, gpin, pwr_pin, rtc, per_en, stop_cnt, ua, ub} = '0;
    alarm = 40'h00_0000_0001;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_pins;
    t_uart;
    t_sys;
    t_irq;
    tally_and_finish;
  end
endmodule : peripheral_interrupt_status_bank_tb_top
